// ### sfs_params.svh
// constants of the serial flash program and erase sequencer
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_OPC_PROGRAM   8'h02
`define SFS_OPC_SECTOR    8'h20
`define SFS_OPC_BLOCK     8'hD8
`define SFS_OPC_CHIP_A    8'hC7
`define SFS_OPC_CHIP_B    8'h60
`define SFS_OPC_PAUSE     8'h75
`define SFS_OPC_RESUME    8'h7A
`define SFS_OPC_WREN      8'h06
`define SFS_OPC_STATUS    8'h05
`define SFS_OPC_BITS      12'd8
`define SFS_ADDR_BITS     12'd32
`define SFS_DATA1_BITS    12'd40
`define SFS_FULL_BITS     12'd2080
`define SFS_PAGE_BYTES    9'd256
`define SFS_HDR_BYTES     9'd4
`define SFS_ARRAY_TOP     24'h400000
`define SFS_PAGE_SIZE     24'h000100
`define SFS_SECTOR_SIZE   24'h001000
`define SFS_BLOCK_SIZE    24'h010000
`define SFS_MCLK_MHZ      40
`define SFS_PAGE_WRITE_TIME_US    700
`define SFS_SECTOR_CLEAR_TIME_US  45000
`define SFS_BLOCK_CLEAR_TIME_US   150000
`define SFS_ARRAY_CLEAR_TIME_US   5000000
`define SFS_PAUSE_LATENCY_US      20
`define SFS_RESUME_TIME_NS        200
`endif

// ### sfs_pkg.sv
// types of the serial flash program and erase sequencer
`default_nettype none
package sfs_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_PAGE, OP_SECT, OP_BLK, OP_CHIP} sfs_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} sfs_state_t;
  typedef struct packed {
    logic       protect_complement;
    logic       small_unit_protect;
    logic       top_bottom_select;
    logic [2:0] protect_level;
  } sfs_prot_t;
endpackage : sfs_pkg
`default_nettype wire

// ### sfs_sequencer.sv
// serial flash program, erase and suspend sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sfs_params.svh"
// Behaviour
// - program is 02h, 24-bit address, 1..256 data bytes in one frame
// - program byte address wraps inside the 256-byte page
// - commands run only if chip select rises on a byte boundary
// - page program needs the write latch set
// - sector, block and chip erase need the write latch set
// - busy is high through the self-timed program cycle
// - finishing any program or erase clears the write latch
// - status read is served while busy
// - program and erase refused on protected page or sector
// - sector erase 20h clears a 4 KB sector
// - block erase D8h clears a 64 KB block
// - chip erase C7h or 60h, exactly eight bits, clears the array
// - chip erase refused if any page is protected
// - suspend 75h only when not paused and busy with page/sector/block
// - suspend ignored during chip erase
// - suspend sets paused flag at once, busy drops within pause latency
// - erase suspended: sector, block and chip erases refused
// - program suspended: every page program refused
// - while paused and idle, status reads, write enable and resume accepted
// - other-sector program during sector erase pause, other-block program during block erase pause, sector or block erase during program pause
// - program or erase on the suspended sector is ignored
// - reset leaves the paused state with the flag at zero
// - resume 7Ah only when paused and idle; restarts the operation
// - status read 05h any time, bit 0 is busy
// - write enable 06h sets the write latch only when idle
module sfs_sequencer
  import sfs_pkg::*;
#(
  parameter logic [31:0] PAGE_WRITE_CYC   = `SFS_PAGE_WRITE_TIME_US * `SFS_MCLK_MHZ,
  parameter logic [31:0] SECTOR_CLEAR_CYC = `SFS_SECTOR_CLEAR_TIME_US * `SFS_MCLK_MHZ,
  parameter logic [31:0] BLOCK_CLEAR_CYC  = `SFS_BLOCK_CLEAR_TIME_US * `SFS_MCLK_MHZ,
  parameter logic [31:0] ARRAY_CLEAR_CYC  = `SFS_ARRAY_CLEAR_TIME_US * `SFS_MCLK_MHZ,
  parameter logic [31:0] PAUSE_CYC        = `SFS_PAUSE_LATENCY_US * `SFS_MCLK_MHZ
) (
  input  wire logic      MCLK,
  input  wire logic      RESET_N,
  input  wire logic      SCK,
  input  wire logic      CS_N,
  input  wire logic      SI,
  input  wire sfs_prot_t PROT,
  input  wire logic [7:0] BUF_IDX,
  output var  logic      SO,
  output var  logic      SO_OE_N,
  output var  logic      BUSY,
  output var  logic      WRITE_LATCH,
  output var  logic      PAUSED_FLAG,
  output var  logic      OP_DONE,
  output var  sfs_op_t   OP_KIND,
  output var  logic [23:0] OP_ADDR,
  output var  logic [8:0] OP_COUNT,
  output var  logic [7:0] BUF_DATA
);
  localparam int PAUSE_N = PAUSE_CYC;

  // link side: frame capture on the serial clock
  logic        fresh;
  logic [11:0] bits;
  logic [11:0] next_bits;
  logic [7:0]  shreg;
  logic [7:0]  next_byte;
  logic [7:0]  opcode;
  logic [23:0] frame_addr;
  logic [7:0]  ptr;
  logic [7:0]  page_buf [256];
  logic [7:0]  st_l1;
  logic [7:0]  st_l2;
  logic [7:0]  sr_hold;
  sfs_prot_t   prot_2;

  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_byte = {shreg[6:0], SI};
    if (fresh) begin
      next_bits = 12'd1;
    end else if (bits == 12'hFFF) begin
      next_bits = bits;
    end else begin
      next_bits = bits + 12'd1;
    end
  end

  always_ff @(posedge SCK) begin
    bits  <= next_bits;
    shreg <= next_byte;
  end

  always_ff @(posedge SCK) begin
    if (next_bits[2:0] == 3'h0) begin
      unique case (next_bits)
        12'd8:   opcode <= next_byte;
        12'd16:  frame_addr[23:16] <= next_byte;
        12'd24:  frame_addr[15:8] <= next_byte;
        12'd32: begin
          frame_addr[7:0] <= next_byte;
          ptr             <= next_byte;
        end
        default: ptr <= ptr + 8'h01;
      endcase
    end
  end

  always_ff @(posedge SCK) begin
    if (next_bits[2:0] == 3'h0 && next_bits > `SFS_ADDR_BITS && opcode == `SFS_OPC_PROGRAM) begin
      page_buf[ptr] <= next_byte;
    end
  end

  // status byte into the link domain, refreshed every byte
  always_ff @(posedge SCK) begin
    st_l1 <= {1'b0, prot_2.small_unit_protect, prot_2.top_bottom_select,
              prot_2.protect_level, WRITE_LATCH, BUSY};
    st_l2 <= st_l1;
    if (next_bits[2:0] == 3'h0) begin
      sr_hold <= st_l2;
    end
  end

  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      SO      <= 1'b0;
      SO_OE_N <= 1'b1;
    end else if (opcode == `SFS_OPC_STATUS && bits >= `SFS_OPC_BITS) begin
      SO      <= sr_hold[~bits[2:0]];
      SO_OE_N <= 1'b0;
    end
  end

  // core side
  sfs_prot_t   prot_1;
  logic        cs_1;
  logic        cs_2;
  logic        cs_3;
  logic        cs_rise;
  sfs_state_t  state;
  logic [31:0] timer;
  logic [31:0] halt;
  sfs_op_t     kind;
  sfs_op_t     held_kind;
  logic [23:0] held_addr;
  logic [31:0] held_timer;
  logic [23:0] op_addr;
  logic        done;
  logic        halt_end;
  logic        start;
  sfs_op_t     next_kind;
  logic [23:0] next_addr;
  logic [23:0] unit;
  logic [31:0] next_load;
  logic        pause_ok;
  logic        resume_ok;
  logic        wel_set;
  logic        whole;
  logic        prot_unit;
  logic        same_hit;
  logic        any_prot;

  always_ff @(posedge MCLK) begin
    prot_1 <= PROT;
    prot_2 <= prot_1;
    cs_1   <= CS_N;
    cs_2   <= cs_1;
    cs_3   <= cs_2;
  end

  assign cs_rise  = cs_2 & ~cs_3;
  assign done     = (state == ST_RUN) && (timer == 32'h1);
  assign halt_end = (state == ST_HALT) && (halt == 32'h1);

  function automatic logic prot_hit(input sfs_prot_t p, input logic [23:0] a);
    logic [23:0] size;
    logic        zone;
    size = '0;
    if (p.protect_level != 3'h0) begin
      if (p.small_unit_protect) begin
        size = `SFS_SECTOR_SIZE << ((p.protect_level > 3'h4) ? 3'h3 : p.protect_level - 3'h1);
      end else begin
        size = `SFS_BLOCK_SIZE << (p.protect_level - 3'h1);
      end
    end
    zone = p.top_bottom_select ? (a < size) : (a >= `SFS_ARRAY_TOP - size);
    return zone ^ p.protect_complement;
  endfunction : prot_hit

  always_comb begin
    next_kind = OP_NONE;
    unit      = `SFS_PAGE_SIZE;
    next_load = PAGE_WRITE_CYC;
    whole     = cs_rise && (bits[2:0] == 3'h0);
    if (opcode == `SFS_OPC_PROGRAM && bits >= `SFS_DATA1_BITS) begin
      next_kind = OP_PAGE;
    end else if (opcode == `SFS_OPC_SECTOR && bits == `SFS_ADDR_BITS) begin
      next_kind = OP_SECT;
      unit      = `SFS_SECTOR_SIZE;
      next_load = SECTOR_CLEAR_CYC;
    end else if (opcode == `SFS_OPC_BLOCK && bits == `SFS_ADDR_BITS) begin
      next_kind = OP_BLK;
      unit      = `SFS_BLOCK_SIZE;
      next_load = BLOCK_CLEAR_CYC;
    end else if ((opcode == `SFS_OPC_CHIP_A || opcode == `SFS_OPC_CHIP_B)
                 && bits == `SFS_OPC_BITS) begin
      next_kind = OP_CHIP;
      next_load = ARRAY_CLEAR_CYC;
    end
    next_addr = frame_addr & (`SFS_ARRAY_TOP - 24'h1) & ~(unit - 24'h1);
    if (next_kind == OP_CHIP) begin
      next_addr = 24'h0;
    end
    prot_unit = prot_hit(prot_2, next_addr)
                | prot_hit(prot_2, next_addr | (unit - 24'h1));
    any_prot  = prot_2.protect_complement | (prot_2.protect_level != 3'h0);
    if (next_kind == OP_BLK || held_kind == OP_BLK) begin
      same_hit = held_addr[21:16] == next_addr[21:16];
    end else begin
      same_hit = held_addr[21:12] == next_addr[21:12];
    end
    start = whole && WRITE_LATCH && (state == ST_IDLE) && (next_kind != OP_NONE);
    if (next_kind == OP_CHIP) begin
      start = start && !any_prot && !PAUSED_FLAG;
    end else begin
      start = start && !prot_unit;
    end
    if (PAUSED_FLAG && next_kind == OP_PAGE) begin
      start = start && (held_kind != OP_PAGE) && !same_hit;
    end
    if (PAUSED_FLAG && (next_kind == OP_SECT || next_kind == OP_BLK)) begin
      start = start && (held_kind == OP_PAGE) && !same_hit;
    end
    pause_ok  = whole && opcode == `SFS_OPC_PAUSE && bits == `SFS_OPC_BITS && !PAUSED_FLAG
                && state == ST_RUN && kind != OP_CHIP && !done;
    resume_ok = whole && opcode == `SFS_OPC_RESUME && bits == `SFS_OPC_BITS
                && PAUSED_FLAG && state == ST_IDLE;
    wel_set   = whole && opcode == `SFS_OPC_WREN && bits == `SFS_OPC_BITS
                && state == ST_IDLE;
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      state   <= ST_IDLE;
      timer   <= 32'h0;
      halt    <= 32'h0;
      kind    <= OP_NONE;
      op_addr <= 24'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state   <= ST_RUN;
            kind    <= next_kind;
            op_addr <= next_addr;
            timer   <= next_load;
          end else if (resume_ok) begin
            state   <= ST_RUN;
            kind    <= held_kind;
            op_addr <= held_addr;
            timer   <= held_timer;
          end
        end
        ST_RUN: begin
          timer <= timer - 32'h1;
          if (pause_ok) begin
            state <= ST_HALT;
            halt  <= PAUSE_CYC;
          end else if (done) begin
            state <= ST_IDLE;
          end
        end
        ST_HALT: begin
          halt <= halt - 32'h1;
          if (halt_end) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      held_kind  <= OP_NONE;
      held_addr  <= 24'h0;
      held_timer <= 32'h0;
    end else if (halt_end) begin
      held_kind  <= kind;
      held_addr  <= op_addr;
      held_timer <= timer;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      PAUSED_FLAG <= 1'b0;
      BUSY        <= 1'b0;
      WRITE_LATCH <= 1'b0;
    end else begin
      if (pause_ok) begin
        PAUSED_FLAG <= 1'b1;
      end else if (resume_ok) begin
        PAUSED_FLAG <= 1'b0;
      end
      if (start || resume_ok) begin
        BUSY <= 1'b1;
      end else if (done || halt_end) begin
        BUSY <= 1'b0;
      end
      if (wel_set) begin
        WRITE_LATCH <= 1'b1;
      end else if (done) begin
        WRITE_LATCH <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      OP_DONE  <= 1'b0;
      OP_KIND  <= OP_NONE;
      OP_ADDR  <= 24'h0;
      OP_COUNT <= 9'h0;
      BUF_DATA <= 8'h0;
    end else begin
      OP_DONE  <= done;
      BUF_DATA <= page_buf[BUF_IDX];
      if (start) begin
        OP_KIND <= next_kind;
        OP_ADDR <= next_addr;
        if (next_kind != OP_PAGE) begin
          OP_COUNT <= 9'h0;
        end else if (bits >= `SFS_FULL_BITS) begin
          OP_COUNT <= `SFS_PAGE_BYTES;
        end else begin
          OP_COUNT <= bits[11:3] - `SFS_HDR_BYTES;
        end
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_prog_needs_latch: assert property (start && next_kind == OP_PAGE |-> WRITE_LATCH)
    else $error("program started without write latch");
  a_erase_needs_latch: assert property (start && next_kind != OP_PAGE |-> WRITE_LATCH)
    else $error("erase started without write latch");
  a_start_busy: assert property (start |=> BUSY && state == ST_RUN)
    else $error("busy not raised on start");
  a_done_clears: assert property (done |=> !WRITE_LATCH && !BUSY && OP_DONE)
    else $error("completion did not clear latch and busy");
  a_whole_frame: assert property (start || pause_ok |-> bits[2:0] == 3'h0)
    else $error("command taken off a byte boundary");
  a_prot_refuse: assert property (start && next_kind != OP_CHIP |-> !prot_unit)
    else $error("protected unit started");
  a_chip_prot: assert property (start && next_kind == OP_CHIP |-> !any_prot)
    else $error("chip erase with protection");
  a_chip_no_pause: assert property (state == ST_RUN && kind == OP_CHIP |=> !PAUSED_FLAG)
    else $error("chip erase paused");
  a_pause_latency: assert property (pause_ok |=> PAUSED_FLAG ##[0:PAUSE_N] !BUSY)
    else $error("busy not dropped within pause latency");
  a_resume_now: assert property (resume_ok |=> !PAUSED_FLAG && BUSY)
    else $error("resume did not restart");
  a_same_unit: assert property (start && PAUSED_FLAG |-> !same_hit)
    else $error("suspended unit targeted");

  c_program: cover property (OP_DONE && OP_KIND == OP_PAGE);
  c_pause: cover property (pause_ok ##1 PAUSED_FLAG);
  c_resume: cover property (resume_ok);
  c_nested: cover property (start && PAUSED_FLAG);
endmodule : sfs_sequencer
`default_nettype wire

// ### sfs_host.sv
// host controller model driving the serial link
`timescale 1ns/10ps
`default_nettype none
module sfs_host (
  output var  logic SCK,
  output var  logic CS_N,
  output var  logic SI,
  input  wire logic SO
);
  initial begin
    SCK = 1'b0;
    SI = 1'b0;
    #1 CS_N = 1'b1;
  end
  // one frame of n bits from the top of v, msb first; sr keeps the last SO bits
  task automatic frame(input logic [2079:0] v, input int n, output logic [7:0] sr);
    sr = 8'h00;
    CS_N = 1'b0;
    for (int i = 0; i < n; i++) begin
      SI = v[2079-i];
      #80 SCK = 1'b1;
      sr = {sr[6:0], SO};
      #80 SCK = 1'b0;
    end
    CS_N = 1'b1;
    SI = ~SI;
    #200;
  endtask : frame
endmodule : sfs_host
`default_nettype wire

// ### sfs_sequencer_tb.sv
// testbench of the program, erase and suspend sequencer
`timescale 1ns/10ps
`default_nettype none
module sfs_sequencer_tb;
  import sfs_pkg::*;
  localparam int PW = 2000;
  localparam int PC = 100;
  logic        MCLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        SCK, CS_N, SI, SO, SO_OE_N;
  logic        oe_low = 1'b0;
  int          done_seen = 0;
  sfs_prot_t   PROT = '0;
  logic [7:0]  BUF_IDX = 8'h00;
  logic        BUSY, WRITE_LATCH, PAUSED_FLAG, OP_DONE;
  sfs_op_t     OP_KIND;
  logic [23:0] OP_ADDR;
  logic [8:0]  OP_COUNT;
  logic [7:0]  BUF_DATA;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) cyc <= cyc + 1;
  always @(negedge MCLK) if (OP_DONE === 1'b1) done_seen++;
  always @(negedge SO_OE_N) oe_low = 1'b1;
  sfs_host i_sfs_host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO));
  sfs_sequencer #(.PAGE_WRITE_CYC(PW), .SECTOR_CLEAR_CYC(3000), .BLOCK_CLEAR_CYC(4000),
    .ARRAY_CLEAR_CYC(3000), .PAUSE_CYC(PC)) i_sfs_sequencer (
    .MCLK(MCLK), .RESET_N(RESET_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .PROT(PROT),
    .BUF_IDX(BUF_IDX), .SO(SO), .SO_OE_N(SO_OE_N), .BUSY(BUSY), .WRITE_LATCH(WRITE_LATCH),
    .PAUSED_FLAG(PAUSED_FLAG), .OP_DONE(OP_DONE), .OP_KIND(OP_KIND), .OP_ADDR(OP_ADDR),
    .OP_COUNT(OP_COUNT), .BUF_DATA(BUF_DATA));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic go(input logic [2079:0] v, input int n);
    logic [7:0] s;
    i_sfs_host.frame(v, n, s);
    repeat (8) @(posedge MCLK);
    #2;
  endtask : go
  task automatic send(input logic [39:0] w, input int n);
    go({w, 2040'h0}, n);
  endtask : send
  task automatic idle(output int c);
    c = 0;
    while (BUSY !== 1'b0 && c < 9000) begin
      @(posedge MCLK);
      #2;
      c++;
    end
    if (c >= 9000) chk("busy timeout", 0, 1);
  endtask : idle
  task automatic t_reset;
    chk("busy", BUSY, 0);
    chk("latch", WRITE_LATCH, 0);
    chk("paused", PAUSED_FLAG, 0);
    chk("kind", OP_KIND, OP_NONE);
    chk("so idle", SO_OE_N, 1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_program;
    logic [2079:0] v;
    logic [7:0]    s;
    int            c;
    int            t0;
    v = {8'h02, 24'h0012F0, 2048'h0};
    for (int k = 0; k < 20; k++) v[2047-8*k -: 8] = 8'(k) ^ 8'h5A;
    go(v, 192);
    chk("no latch", BUSY, 0);
    send({8'h06, 32'h0}, 8);
    chk("latch set", WRITE_LATCH, 1);
    go(v, 192);
    t0 = cyc;
    chk("kind", OP_KIND, OP_PAGE);
    chk("count", OP_COUNT, 20);
    chk("page addr", OP_ADDR, 24'h001200);
    i_sfs_host.frame({8'h05, 2072'h0}, 16, s);
    chk("status busy", s[0], 1);
    chk("status latch", s[1], 1);
    chk("so driven", oe_low, 1);
    chk("so released", SO_OE_N, 1);
    idle(c);
    chk("page time", (cyc - t0 > PW - 24) && (cyc - t0 <= PW), 1);
    chk("latch clear", WRITE_LATCH, 0);
    BUF_IDX = 8'hF0;
    repeat (2) @(posedge MCLK);
    #2 chk("first slot", BUF_DATA, 8'h5A);
    chk("done pulse", done_seen, 1);
    BUF_IDX = 8'h03;
    repeat (2) @(posedge MCLK);
    #2 chk("wrapped slot", BUF_DATA, 8'h49);
    $display("t_program done");
  endtask : t_program
  task automatic t_frames;
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h003000, 8'h0}, 31);
    chk("short erase", BUSY, 0);
    send({8'hC7, 32'h0}, 9);
    chk("long chip", BUSY, 0);
    chk("latch kept", WRITE_LATCH, 1);
    $display("t_frames done");
  endtask : t_frames
  task automatic t_erases;
    logic [7:0]  op [4] = '{8'h20, 8'hD8, 8'hC7, 8'h60};
    sfs_op_t     kd [4] = '{OP_SECT, OP_BLK, OP_CHIP, OP_CHIP};
    logic [23:0] ad [4] = '{24'h012000, 24'h010000, 24'h0, 24'h0};
    int          c;
    for (int i = 0; i < 4; i++) begin
      send({8'h06, 32'h0}, 8);
      send({op[i], 24'h012345, 8'h0}, (i < 2) ? 32 : 8);
      chk("erase busy", BUSY, 1);
      chk("erase kind", OP_KIND, kd[i]);
      chk("erase addr", OP_ADDR, ad[i]);
      idle(c);
      chk("erase latch", WRITE_LATCH, 0);
    end
    send({8'h20, 24'h012345, 8'h0}, 32);
    chk("erase no latch", BUSY, 0);
    $display("t_erases done");
  endtask : t_erases
  task automatic t_protect;
    int c;
    PROT = sfs_prot_t'(6'h01);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h3F5000, 8'h0}, 32);
    chk("prot sector", BUSY, 0);
    send({8'h02, 24'h3FFF00, 8'h11}, 40);
    chk("prot page", BUSY, 0);
    send({8'hC7, 32'h0}, 8);
    chk("prot chip", BUSY, 0);
    send({8'h20, 24'h000000, 8'h0}, 32);
    chk("open sector", BUSY, 1);
    idle(c);
    PROT = '0;
    $display("t_protect done");
  endtask : t_protect
  task automatic t_suspend;
    int c;
    send({8'h75, 32'h0}, 8);
    chk("idle pause", PAUSED_FLAG, 0);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h002000, 8'h0}, 32);
    send({8'h75, 32'h0}, 8);
    chk("paused", PAUSED_FLAG, 1);
    idle(c);
    chk("pause latency", c <= PC, 1);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 24'h002800, 8'h0}, 32);
    chk("erase same sector", BUSY, 0);
    send({8'h02, 24'h002800, 8'hC3}, 40);
    chk("same sector", BUSY, 0);
    send({8'hD8, 24'h050000, 8'h0}, 32);
    chk("erase in pause", BUSY, 0);
    send({8'h02, 24'h005000, 8'hC3}, 40);
    chk("program in pause", OP_KIND, OP_PAGE);
    send({8'h75, 32'h0}, 8);
    chk("second pause", PAUSED_FLAG, 1);
    idle(c);
    send({8'h7A, 32'h0}, 8);
    chk("resume flag", PAUSED_FLAG, 0);
    chk("resume busy", BUSY, 1);
    idle(c);
    chk("resume latch", WRITE_LATCH, 0);
    $display("t_suspend done");
  endtask : t_suspend
  task automatic t_chip_pause;
    int c;
    send({8'h06, 32'h0}, 8);
    send({8'h60, 32'h0}, 8);
    send({8'h75, 32'h0}, 8);
    chk("chip no pause", PAUSED_FLAG, 0);
    chk("chip runs", BUSY, 1);
    idle(c);
    $display("t_chip_pause done");
  endtask : t_chip_pause
  task automatic t_pause_reset;
    send({8'h06, 32'h0}, 8);
    send({8'h02, 24'h006000, 8'h3C}, 40);
    send({8'h75, 32'h0}, 8);
    send({8'h06, 32'h0}, 8);
    send({8'h02, 24'h009000, 8'h3C}, 40);
    chk("program in pause", BUSY, 0);
    RESET_N = 1'b0;
    repeat (8) @(posedge MCLK);
    #2 RESET_N = 1'b1;
    repeat (4) @(posedge MCLK);
    #2 chk("reset pause", PAUSED_FLAG, 0);
    $display("t_pause_reset done");
  endtask : t_pause_reset
  initial begin
    repeat (8) @(posedge MCLK);
    #2 RESET_N = 1'b1;
    repeat (4) @(posedge MCLK);
    #2;
    t_reset();
    t_program();
    t_frames();
    t_erases();
    t_protect();
    t_suspend();
    t_chip_pause();
    t_pause_reset();
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    fail_count++;
    tally_and_finish();
  end
endmodule : sfs_sequencer_tb
`default_nettype wire
